// ==== rtl/srsq_params.svh ====
// Constants and behaviour notes for the system reset sequencer
// Notes on behaviour
// [RL1] Reset pin low or either watchdog overflow request starts system reset.
// [RL2] Reset ends when pin goes high or a watchdog request pulse has passed.
// [RL3] Main oscillator is held stopped while the reset pin is low.
// [RL4] Pin or second-watchdog reset releases through a 2^15-cycle wait.
// [RL5] First-watchdog reset skips the wait; main oscillator keeps running.
// [RL6] Pin/second-watchdog reset stops core clocks until the wait ends.
// [RL7] Pin/second-watchdog reset halts peripheral clocks; sub osc runs on.
// [RL8] Pin/second-watchdog reset stops first-watchdog clock until reset ends.
// [RL9] First-watchdog reset keeps oscillators and core clocks; divider /8.
// [RL10] Any reset initializes CPU and all peripheral registers.
// [RL11] Internal RAM is kept through reset; writes are blocked during reset.
// [RL12] Second watchdog stops in reset, restarts after any settle wait.
// [RL13] Other peripherals stop in reset, may start after settle wait.
// [RL14] All I/O lines are high impedance while reset is active.
// [RL15] Watchdog requests are synchronous pulses raising the same reset.
`ifndef SRSQ_PARAMS_SVH
`define SRSQ_PARAMS_SVH
`define SRSQ_SETTLE_EXP 16
`define SRSQ_SETTLE_CYCLES 16'h8000
`define SRSQ_DIV_SEL_W 3
`define SRSQ_DIV_SEL_RESET 3'h3
`endif

// ==== rtl/srsq_pkg.sv ====
// Types shared by the system reset sequencer
package srsq_pkg;
  typedef enum logic [1:0] {
    SRSQ_RUN = 2'b00,
    SRSQ_HOLD = 2'b01,
    SRSQ_SETTLE = 2'b10
  } srsq_state_t;
  typedef enum logic [1:0] {
    SRSQ_SRC_NONE = 2'b00,
    SRSQ_SRC_PIN = 2'b01,
    SRSQ_SRC_WD1 = 2'b10,
    SRSQ_SRC_WD2 = 2'b11
  } srsq_src_t;
endpackage : srsq_pkg

// ==== rtl/srsq_sequencer.sv ====
// System reset sequencer: sources, clock gating, settle wait, reset outputs
`include "srsq_params.svh"
module srsq_sequencer (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reset_pin_b,
  input wire logic first_watchdog_reset_request,
  input wire logic second_watchdog_reset_request,
  input wire logic cpu_ram_write,
  output logic main_osc_enable,
  output logic sub_osc_enable,
  output logic sys_clk_enable,
  output logic processor_clock_enable,
  output logic periph_clk_enable,
  output logic wdt1_clk_enable,
  output logic wdt2_run,
  output logic periph_start_allow,
  output logic cpu_reset_b,
  output logic periph_reg_reset_b,
  output logic io_output_enable,
  output logic ram_write_enable,
  output logic [`SRSQ_DIV_SEL_W-1:0] osc_settle_time_select,
  output logic [`SRSQ_DIV_SEL_W-1:0] clk_div_select,
  output logic [1:0] reset_cause
);
  // ****************************************
  // Reset detection
  // ****************************************
  srsq_pkg::srsq_state_t state_reg;
  srsq_pkg::srsq_state_t state_next;
  srsq_pkg::srsq_src_t src_reg;
  srsq_pkg::srsq_src_t src_next;
  logic [`SRSQ_DIV_SEL_W-1:0] div_reg;
  logic [`SRSQ_DIV_SEL_W-1:0] sts_reg;
  logic settle_done;

  wire logic pin_low = !reset_pin_b;
  wire logic wd1_req = first_watchdog_reset_request; // [RL15]
  wire logic wd2_req = second_watchdog_reset_request; // [RL15]
  wire logic any_req = pin_low || wd1_req || wd2_req; // [RL1]
  // Pin has priority, then second watchdog (stricter clock handling)
  wire srsq_pkg::srsq_src_t req_src =
    pin_low ? srsq_pkg::SRSQ_SRC_PIN :
    wd2_req ? srsq_pkg::SRSQ_SRC_WD2 :
    wd1_req ? srsq_pkg::SRSQ_SRC_WD1 : srsq_pkg::SRSQ_SRC_NONE;
  wire logic in_hold = (state_reg == srsq_pkg::SRSQ_HOLD);
  wire logic in_settle = (state_reg == srsq_pkg::SRSQ_SETTLE);
  wire logic src_wd1 = (src_reg == srsq_pkg::SRSQ_SRC_WD1);
  wire logic full_reset = (in_hold || in_settle) && !src_wd1;

  // ****************************************
  // State machine
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    src_next = src_reg;
    unique case (state_reg)
      srsq_pkg::SRSQ_RUN:
      begin
        if (any_req)
        begin
          state_next = srsq_pkg::SRSQ_HOLD; // [RL1]
          src_next = req_src;
        end
      end
      srsq_pkg::SRSQ_HOLD:
      begin
        if (any_req)
        begin
          // A stronger source upgrades a first-watchdog reset
          if (req_src != srsq_pkg::SRSQ_SRC_WD1)
            src_next = req_src;
        end
        else if (src_wd1)
          state_next = srsq_pkg::SRSQ_RUN; // [RL2] [RL5]
        else
          state_next = srsq_pkg::SRSQ_SETTLE; // [RL2] [RL4]
      end
      srsq_pkg::SRSQ_SETTLE:
      begin
        if (any_req)
        begin
          state_next = srsq_pkg::SRSQ_HOLD;
          src_next = req_src;
        end
        else if (settle_done)
          state_next = srsq_pkg::SRSQ_RUN; // [RL4]
      end
      default:
      begin
        state_next = srsq_pkg::SRSQ_HOLD;
        src_next = srsq_pkg::SRSQ_SRC_PIN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= srsq_pkg::SRSQ_HOLD;
      src_reg <= srsq_pkg::SRSQ_SRC_PIN;
    end
    else
    begin
      state_reg <= state_next;
      src_reg <= src_next;
    end
  end

  // ****************************************
  // Settle wait
  // ****************************************
  srsq_settle_counter u_settle (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clear(!in_settle),
    .count_en(in_settle),
    .done(settle_done)
  ); // [RL4]

  // ****************************************
  // Divider and settle select reset values
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_reg <= `SRSQ_DIV_SEL_RESET;
      sts_reg <= `SRSQ_DIV_SEL_RESET;
    end
    else if (in_hold)
    begin
      div_reg <= `SRSQ_DIV_SEL_RESET; // [RL6] [RL9]
      sts_reg <= `SRSQ_DIV_SEL_RESET;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign main_osc_enable = !(in_hold && pin_low); // [RL3] [RL9]
  assign sub_osc_enable = 1'b1; // [RL7]
  assign sys_clk_enable = !full_reset; // [RL6] [RL9]
  assign processor_clock_enable = !full_reset; // [RL6] [RL9]
  assign periph_clk_enable = !(in_hold || full_reset); // [RL7] [RL9]
  assign wdt1_clk_enable = !(in_hold && !src_wd1); // [RL8] [RL9]
  assign wdt2_run = !(in_hold || full_reset); // [RL12]
  assign periph_start_allow = !(in_hold || full_reset); // [RL13]
  assign cpu_reset_b = !(in_hold || full_reset); // [RL10] [RL4]
  assign periph_reg_reset_b = !in_hold; // [RL10]
  assign io_output_enable = !(in_hold || full_reset); // [RL14]
  assign ram_write_enable = cpu_ram_write && !any_req && !in_hold; // [RL11]
  assign osc_settle_time_select = sts_reg;
  assign clk_div_select = div_reg;
  assign reset_cause = src_reg;
endmodule : srsq_sequencer

// ==== rtl/srsq_settle_counter.sv ====
// Oscillation settle counter
`include "srsq_params.svh"
module srsq_settle_counter (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic count_en,
  output logic done
);
  logic [`SRSQ_SETTLE_EXP-1:0] count_reg;
  logic [`SRSQ_SETTLE_EXP-1:0] count_next;
  wire logic at_end = (count_reg == `SRSQ_SETTLE_CYCLES - 16'h0001);
  assign count_next = clear ? 16'h0000 :
                      (count_en && !at_end) ? count_reg + 16'h0001 : count_reg;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      count_reg <= 16'h0000;
    else
      count_reg <= count_next;
  end
  assign done = count_en && at_end;
endmodule : srsq_settle_counter

// ==== test/srsq_reset_partner.sv ====
// Model of the reset pin driver and both watchdog request sources
module srsq_reset_partner (
  input wire logic clk_sys,
  output logic reset_pin_b,
  output logic first_watchdog_reset_request,
  output logic second_watchdog_reset_request
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reset_pin_b = 1'b1;
    first_watchdog_reset_request = 1'b0;
    second_watchdog_reset_request = 1'b0;
  end
  // Holds one source active for len cycles, changing just after an edge
  task automatic assert_src(input logic [1:0] src, input int len);
    @(posedge clk_sys);
    #1;
    reset_pin_b = (src != 2'h1);
    first_watchdog_reset_request = (src == 2'h2);
    second_watchdog_reset_request = (src == 2'h3);
    repeat (len) @(posedge clk_sys);
    #1;
    reset_pin_b = 1'b1;
    first_watchdog_reset_request = 1'b0;
    second_watchdog_reset_request = 1'b0;
  endtask : assert_src
endmodule : srsq_reset_partner

// ==== test/srsq_sequencer_asserts.sv ====
// Checker for the system reset sequencer
module srsq_sequencer_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reset_pin_b,
  input wire logic first_watchdog_reset_request,
  input wire logic second_watchdog_reset_request,
  input wire logic cpu_ram_write,
  input wire logic main_osc_enable,
  input wire logic sub_osc_enable,
  input wire logic sys_clk_enable,
  input wire logic periph_clk_enable,
  input wire logic io_output_enable,
  input wire logic periph_reg_reset_b,
  input wire logic ram_write_enable
);
  wire logic req = !reset_pin_b || first_watchdog_reset_request ||
    second_watchdog_reset_request;
  logic [15:0] settle_reg;
  // Counts cycles of a running settle wait
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      settle_reg <= 16'h0;
    else
      settle_reg <= (!sys_clk_enable && periph_reg_reset_b) ?
        settle_reg + 16'h1 : 16'h0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_sub_osc_on: assert property (sub_osc_enable)
    else $error("sub oscillator stopped");
  chk_osc_pin_stop: assert property (!reset_pin_b ##1 !reset_pin_b |->
    !main_osc_enable) else $error("main oscillator runs in pin reset");
  chk_io_hiz: assert property (req |=> !io_output_enable)
    else $error("outputs driven in reset");
  chk_reg_init: assert property (req |=> !periph_reg_reset_b)
    else $error("registers not reset");
  chk_ram_block: assert property (ram_write_enable |->
    cpu_ram_write && !req && periph_reg_reset_b)
    else $error("ram write in reset");
  chk_wd1_core: assert property (first_watchdog_reset_request &&
    reset_pin_b && !second_watchdog_reset_request && sys_clk_enable |=>
    sys_clk_enable) else $error("core clock stopped by first watchdog");
  chk_wd1_skip: assert property (!periph_clk_enable &&
    sys_clk_enable && !req |=> periph_clk_enable)
    else $error("first watchdog waited");
  chk_settle_len: assert property ($rose(sys_clk_enable) &&
    periph_reg_reset_b |-> settle_reg == 16'h8000)
    else $error("settle wait length wrong");
  cover property (first_watchdog_reset_request);
  cover property (second_watchdog_reset_request);
  cover property (!reset_pin_b);
endmodule : srsq_sequencer_asserts
bind srsq_sequencer srsq_sequencer_asserts i_srsq_sequencer_asserts (
  .clk_sys, .rst_b, .reset_pin_b, .first_watchdog_reset_request,
  .second_watchdog_reset_request, .cpu_ram_write, .main_osc_enable,
  .sub_osc_enable, .sys_clk_enable, .periph_clk_enable, .io_output_enable,
  .periph_reg_reset_b, .ram_write_enable);

// ==== test/tb_srsq_sequencer.sv ====
// Self-checking bench for the system reset sequencer
module tb_srsq_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cpu_ram_write = 1'b0;
  logic reset_pin_b, first_watchdog_reset_request;
  logic second_watchdog_reset_request, main_osc_enable, sub_osc_enable;
  logic sys_clk_enable, processor_clock_enable, periph_clk_enable;
  logic wdt1_clk_enable, wdt2_run, periph_start_allow, cpu_reset_b;
  logic periph_reg_reset_b, io_output_enable, ram_write_enable;
  logic [2:0] osc_settle_time_select, clk_div_select;
  logic [1:0] reset_cause;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  logic [31:0] seed = 32'h5871;
  always #20 clk_sys = ~clk_sys;
  srsq_reset_partner i_srsq_reset_partner (.clk_sys, .reset_pin_b,
    .first_watchdog_reset_request, .second_watchdog_reset_request);
  srsq_sequencer i_srsq_sequencer (.clk_sys, .rst_b, .reset_pin_b,
    .first_watchdog_reset_request, .second_watchdog_reset_request,
    .cpu_ram_write, .main_osc_enable, .sub_osc_enable, .sys_clk_enable,
    .processor_clock_enable, .periph_clk_enable, .wdt1_clk_enable, .wdt2_run,
    .periph_start_allow, .cpu_reset_b, .periph_reg_reset_b, .io_output_enable,
    .ram_write_enable, .osc_settle_time_select, .clk_div_select, .reset_cause);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic wait_run(output int k);
    k = 0;
    while (cpu_reset_b !== 1'b1 && k < 40000)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    check({3'h0, periph_start_allow}, 4'h1);
  endtask : wait_run
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      err_count++;
      summarize();
    end
    #1;
    seed = xs(seed);
    cpu_ram_write = seed[0];
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    check({osc_settle_time_select, sub_osc_enable}, 4'h7);
    check({clk_div_select, cpu_reset_b}, 4'h6);
    wait_run(n);
    $display("power-up test done");
    repeat (8)
    begin
      i_srsq_reset_partner.assert_src(2'h2, int'(seed[1:0]) + 1);
      check({main_osc_enable, sys_clk_enable, periph_clk_enable,
        io_output_enable}, 4'hC);
      @(posedge clk_sys);
      #2;
      check({periph_clk_enable, io_output_enable, reset_cause}, 4'hE);
      check({2'h0, ram_write_enable, wdt1_clk_enable},
        {2'h0, cpu_ram_write, 1'b1});
    end
    $display("first watchdog test done");
    i_srsq_reset_partner.assert_src(2'h1, 4);
    check({wdt1_clk_enable, wdt2_run, processor_clock_enable,
      periph_reg_reset_b}, 4'h0);
    @(posedge clk_sys);
    #2;
    check({wdt1_clk_enable, wdt2_run, reset_cause}, 4'h9);
    i_srsq_reset_partner.assert_src(2'h3, 1);
    wait_run(n);
    check({1'b0, n >= 32768, reset_cause}, 4'h7);
    $display("pin and second watchdog test done");
    summarize();
  end
endmodule : tb_srsq_sequencer
